// file: bench/dtsc_top_tb.sv
// self-checking bench for the debug trace status and control registers
`timescale 1ns/100ps
`include "dtsc_defs.svh"

module dtsc_top_tb;
    logic core_clk;
    logic reset, por_reset, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic secure, line_captured, seq_state_valid, session_end;
    logic [2:0] seq_state;
    logic cmp_a_hit, cmp_b_hit, above_a, below_b;
    logic armed, itrig, trace_enable, read_allow, align, match0, match1;
    logic [1:0] vis, trace_mode;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 32'he072_86a5;

    dtsc_top DUT (.core_clk_i(core_clk), .reset_i(reset),
        .por_reset_i(por_reset), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write),
        .avs_byteenable_i(avs_byteenable), .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
        .secure_i(secure), .line_captured_i(line_captured),
        .seq_state_valid_i(seq_state_valid), .seq_state_i(seq_state),
        .session_end_i(session_end), .cmp_a_hit_i(cmp_a_hit),
        .cmp_b_hit_i(cmp_b_hit), .above_a_i(above_a), .below_b_i(below_b),
        .armed_o(armed), .immediate_trigger_o(itrig),
        .comparator_visibility_o(vis), .trace_enable_o(trace_enable),
        .trace_read_allow_o(read_allow), .trace_mode_o(trace_mode),
        .trigger_alignment_o(align), .match0_o(match0), .match1_o(match1));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one avalon transfer; the request stands until waitrequest is seen low
    task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        int i;
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin
            chk("waitrequest", avs_waitrequest, 1'b0);
            summarize();
        end
    endtask

    task rdchk(input logic [5:0] idx, input logic [7:0] exp,
            input string name);
        bus(1'b0, idx, 8'h00);
        chk(name, rdata, {24'h0, exp});
    endtask

    // settle past the edge before looking at outputs
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task seq(input logic [2:0] s);
        @(posedge core_clk);
        seq_state <= s;
        seq_state_valid <= 1'b1;
        @(posedge core_clk);
        seq_state_valid <= 1'b0;
    endtask

    // holding the strobe n cycles stores n lines
    task lines(input int n);
        @(posedge core_clk);
        line_captured <= 1'b1;
        repeat (n) @(posedge core_clk);
        line_captured <= 1'b0;
    endtask

    function automatic logic [1:0] exp_match(input int p, input logic a,
            input logic b, input logic ab, input logic bb);
        case (p)
            0: exp_match = {b, a};
            1: exp_match = {1'b0, ab & bb};
            2: exp_match = {1'b0, ~(ab & bb)};
            default: exp_match = {1'b0, a};
        endcase
    endfunction

    function automatic logic [7:0] setup_byte(input int m);
        setup_byte = 8'h40 | 8'(m << 2) | 8'(m & 1);
    endfunction

    initial begin
        {reset, por_reset} = 2'b11;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        {secure, line_captured, seq_state_valid, seq_state} = '0;
        {session_end, cmp_a_hit, cmp_b_hit, above_a, below_b} = '0;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        por_reset <= 1'b0;
        rdchk(`DTSC_IDX_STATUS, 8'h00, "status reset");
        rdchk(`DTSC_IDX_COUNT, 8'h00, "count reset");
        bus(1'b1, 6'h3F, 8'hFF);
        rdchk(6'h3F, 8'h00, "unmapped");
        // every mode and alignment while disarmed
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, `DTSC_IDX_SETUP, setup_byte(m));
            tick(1);
            chk("trace mode", trace_mode, m);
            chk("alignment", align, m & 1);
            chk("read allow", read_allow, 1);
            rdchk(`DTSC_IDX_SETUP, setup_byte(m), "setup");
        end
        @(posedge core_clk);
        secure <= 1'b1;
        tick(4);
        chk("enable secured", trace_enable, 0);
        bus(1'b1, `DTSC_IDX_SETUP, 8'h4D);
        tick(0);
        chk("enable write secured", trace_enable, 0);
        @(posedge core_clk);
        secure <= 1'b0;
        tick(4);
        chk("enable refused", trace_enable, 0);
        bus(1'b1, `DTSC_IDX_SETUP, 8'h4D);
        tick(1);
        chk("enable open", trace_enable, 1);
        // pairing codes against random comparator hits
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, `DTSC_IDX_PAIRING, 8'(p));
            rdchk(`DTSC_IDX_PAIRING, 8'(p), "pairing");
            repeat (8) begin
                @(posedge core_clk);
                {cmp_a_hit, cmp_b_hit, above_a, below_b} <= 4'($random(seed));
                tick(1);
                chk("match", {match1, match0}, exp_match(p, cmp_a_hit,
                    cmp_b_hit, above_a, below_b));
            end
        end
        // arming enters state 1 and locks setup and pairing
        bus(1'b1, `DTSC_IDX_CONTROL, 8'h80);
        tick(1);
        chk("armed", armed, 1);
        chk("read allow armed", read_allow, 0);
        rdchk(`DTSC_IDX_STATUS, 8'h01, "status armed");
        bus(1'b1, `DTSC_IDX_SETUP, 8'h00);
        bus(1'b1, `DTSC_IDX_PAIRING, 8'h00);
        rdchk(`DTSC_IDX_SETUP, 8'h4D, "setup locked");
        rdchk(`DTSC_IDX_PAIRING, 8'h03, "pairing locked");
        bus(1'b1, `DTSC_IDX_CONTROL, 8'hC2);
        tick(0);
        chk("trigger pulse", itrig, 1);
        chk("visibility", vis, 2);
        tick(1);
        chk("trigger low", itrig, 0);
        rdchk(`DTSC_IDX_CONTROL, 8'h82, "control");
        seq(3'h2);
        rdchk(`DTSC_IDX_STATUS, 8'h02, "state two");
        seq(3'h5);
        rdchk(`DTSC_IDX_STATUS, 8'h02, "state reserved");
        seq(3'h4);
        rdchk(`DTSC_IDX_STATUS, 8'h04, "state final");
        // full only at the 64th line, mirrored in the count
        lines(63);
        rdchk(`DTSC_IDX_STATUS, 8'h04, "not full");
        rdchk(`DTSC_IDX_COUNT, 8'h3F, "count 63");
        lines(1);
        rdchk(`DTSC_IDX_STATUS, 8'h84, "full status");
        rdchk(`DTSC_IDX_COUNT, 8'h80, "full count");
        // system reset keeps the full flag
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rdchk(`DTSC_IDX_COUNT, 8'h80, "full after reset");
        // rearming clears full and forces state 1
        bus(1'b1, `DTSC_IDX_CONTROL, 8'h80);
        rdchk(`DTSC_IDX_STATUS, 8'h01, "rearmed");
        rdchk(`DTSC_IDX_COUNT, 8'h00, "count rearmed");
        seq(3'h3);
        bus(1'b1, `DTSC_IDX_CONTROL, 8'h00);
        tick(1);
        chk("disarmed", armed, 0);
        rdchk(`DTSC_IDX_STATUS, 8'h03, "state kept");
        // internal end returns to state 0
        bus(1'b1, `DTSC_IDX_CONTROL, 8'h80);
        seq(3'h2);
        @(posedge core_clk);
        session_end <= 1'b1;
        @(posedge core_clk);
        session_end <= 1'b0;
        tick(1);
        chk("ended", armed, 0);
        rdchk(`DTSC_IDX_STATUS, 8'h00, "state cleared");
        // power-on reset clears the full flag
        bus(1'b1, `DTSC_IDX_CONTROL, 8'h80);
        lines(64);
        @(posedge core_clk);
        por_reset <= 1'b1;
        @(posedge core_clk);
        por_reset <= 1'b0;
        rdchk(`DTSC_IDX_COUNT, 8'h00, "full after por");
        summarize();
    end
endmodule // dtsc_top_tb

// file: verilog/dtsc_defs.svh
// register offsets, field positions and reset values of the debug trace block
`ifndef DTSC_DEFS_SVH
`define DTSC_DEFS_SVH

// register indices; byte address is four times the index
`define DTSC_IDX_CONTROL 6'h20
`define DTSC_IDX_STATUS 6'h21
`define DTSC_IDX_SETUP 6'h22
`define DTSC_IDX_PAIRING 6'h23
`define DTSC_IDX_COUNT 6'h26

// debug_control_one fields
`define DTSC_CTRL_ARM_BIT 7
`define DTSC_CTRL_IMMEDIATE_TRIGGER_REQUEST_BIT 6
`define DTSC_CTRL_VIS_LSB 0

// debug_state_status and trace_line_count fields
`define DTSC_FULL_BIT 7

// trace_setup fields
`define DTSC_SETUP_REQ_BIT 6
`define DTSC_SETUP_MODE_LSB 2
`define DTSC_SETUP_ALIGN_BIT 0

// state field codes
`define DTSC_SSF_IDLE 3'h0
`define DTSC_SSF_FIRST 3'h1
`define DTSC_SSF_FINAL 3'h4

// last line count before the wrap; one more captured line sets the full flag
`define DTSC_CNT_LAST 6'h3F

`define DTSC_BYTE_ZERO 8'h00
`define DTSC_WORD_ZERO 32'h0000_0000

`endif

// file: verilog/dtsc_pkg.sv
// types shared by the debug trace status and control block
package dtsc_pkg;

    typedef enum logic [1:0] {
        DTSC_MODE_NORMAL = 2'h0,
        DTSC_MODE_LOOP_SUPPRESS = 2'h1,
        DTSC_MODE_DETAIL = 2'h2,
        DTSC_MODE_PC_ONLY = 2'h3
    } dtsc_trace_mode_type;

    typedef enum logic [1:0] {
        DTSC_PAIR_SEPARATE = 2'h0,
        DTSC_PAIR_INSIDE = 2'h1,
        DTSC_PAIR_OUTSIDE = 2'h2,
        DTSC_PAIR_RESERVED = 2'h3
    } dtsc_pairing_type;

    // bus handshake phase, one-hot
    typedef enum logic [1:0] {
        DTSC_BUS_WAIT = 2'b01,
        DTSC_BUS_DONE = 2'b10
    } dtsc_bus_state_type;

endpackage

// file: verilog/dtsc_top.sv
// debug trace status, trace setup and comparator pairing registers
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "dtsc_defs.svh"

module dtsc_top
    import dtsc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic por_reset_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic secure_i,
    input wire logic line_captured_i,
    input wire logic seq_state_valid_i,
    input wire logic [2:0] seq_state_i,
    input wire logic session_end_i,
    input wire logic cmp_a_hit_i,
    input wire logic cmp_b_hit_i,
    input wire logic above_a_i,
    input wire logic below_b_i,
    output logic armed_o,
    output logic immediate_trigger_o,
    output logic [1:0] comparator_visibility_o,
    output logic trace_enable_o,
    output logic trace_read_allow_o,
    output logic [1:0] trace_mode_o,
    output logic trigger_alignment_o,
    output logic match0_o,
    output logic match1_o
);

    dtsc_bus_state_type bus_state_reg;
    dtsc_trace_mode_type trace_mode_select_reg;
    dtsc_pairing_type comparator_pairing_field_reg;
    logic secure_meta_reg, secure_reg, arm_reg, trigger_reg;
    logic buffer_full_flag_reg, trace_request_enable_reg;
    logic trigger_alignment_reg, read_allow_reg;
    logic [1:0] visibility_reg;
    logic [5:0] line_count_reg, reg_idx;
    logic [2:0] sequencer_state_field_reg;
    logic [31:0] readdata_reg;
    logic match0_reg, match1_reg, match0_next, match1_next, inside_range;
    logic any_req, wr_fire, addr_ok, wr_ctrl, wr_setup, wr_pair;
    logic arm_set, arm_clear_sw, count_wrap;
    logic [7:0] status_rd, count_rd, ctrl_rd, setup_rd, pair_rd, rd_byte;
    assign any_req = avs_read_i || avs_write_i;
    assign wr_fire = avs_write_i && (bus_state_reg == DTSC_BUS_DONE)
        && avs_byteenable_i[0];
    assign addr_ok = (avs_address_i[1:0] == 2'b00);
    assign reg_idx = avs_address_i[7:2];
    assign wr_ctrl = wr_fire && addr_ok && (reg_idx == `DTSC_IDX_CONTROL);
    assign wr_setup = wr_fire && addr_ok && (reg_idx == `DTSC_IDX_SETUP);
    assign wr_pair = wr_fire && addr_ok && (reg_idx == `DTSC_IDX_PAIRING);
    assign arm_set = wr_ctrl && avs_writedata_i[`DTSC_CTRL_ARM_BIT];
    assign arm_clear_sw = wr_ctrl && !avs_writedata_i[`DTSC_CTRL_ARM_BIT]
        && arm_reg;
    assign count_wrap = arm_reg && line_captured_i
        && (line_count_reg == `DTSC_CNT_LAST);
    // bus handshake: waitrequest drops one cycle after the request rises
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_reset_i) begin
            bus_state_reg <= DTSC_BUS_WAIT;
        end else begin
            case (bus_state_reg)
                DTSC_BUS_WAIT: begin
                    if (any_req) begin
                        bus_state_reg <= DTSC_BUS_DONE;
                    end
                end
                DTSC_BUS_DONE: bus_state_reg <= DTSC_BUS_WAIT;
                default: bus_state_reg <= DTSC_BUS_WAIT;
            endcase
        end
    end
    // secure level comes from outside the clock domain
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_reset_i) begin
            secure_meta_reg <= 1'b1;
            secure_reg <= 1'b1;
        end else begin
            secure_meta_reg <= secure_i;
            secure_reg <= secure_meta_reg;
        end
    end

    // arm bit and visibility field accept writes anytime, the trigger pulse only while not secure
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_reset_i) begin
            arm_reg <= 1'b0;
            visibility_reg <= 2'b00;
            trigger_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                arm_reg <= avs_writedata_i[`DTSC_CTRL_ARM_BIT];
                visibility_reg <= avs_writedata_i[`DTSC_CTRL_VIS_LSB +: 2];
            end else if (session_end_i) begin
                arm_reg <= 1'b0;
            end
            // secure mode cannot start a session by trigger
            trigger_reg <= wr_ctrl && !secure_reg
                && avs_writedata_i[`DTSC_CTRL_IMMEDIATE_TRIGGER_REQUEST_BIT];
        end
    end

    // buffer full flag and line count survive system reset
    always_ff @(posedge core_clk_i) begin
        if (por_reset_i) begin
            buffer_full_flag_reg <= 1'b0;
            line_count_reg <= 6'h00;
        // a capture at a system reset edge is dropped, flag left untouched
        end else if (!reset_i) begin
            // set on wrap, set wins over clear
            if (count_wrap) begin
                buffer_full_flag_reg <= 1'b1;
            end else if (arm_set) begin
                buffer_full_flag_reg <= 1'b0;
            end
            if (arm_set) begin
                line_count_reg <= 6'h00;
            end else if (arm_reg && line_captured_i) begin
                line_count_reg <= line_count_reg + 6'h01;
            end
        end
    end

    // state field tracks the sequencer
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_reset_i) begin
            sequencer_state_field_reg <= `DTSC_SSF_IDLE;
        end else begin
            if (arm_set) begin
                sequencer_state_field_reg <= `DTSC_SSF_FIRST;
            end else if (session_end_i && arm_reg) begin
                sequencer_state_field_reg <= `DTSC_SSF_IDLE;
            end else if (arm_clear_sw) begin
                sequencer_state_field_reg <= sequencer_state_field_reg;
            end else if (arm_reg && seq_state_valid_i
                    && seq_state_i <= `DTSC_SSF_FINAL) begin
                sequencer_state_field_reg <= seq_state_i;
            end
        end
    end

    // trace setup fields
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_reset_i) begin
            trace_request_enable_reg <= 1'b0;
            trace_mode_select_reg <= DTSC_MODE_NORMAL;
            trigger_alignment_reg <= 1'b0;
        end else begin
            if (wr_setup && !secure_reg && !arm_reg) begin
                trace_request_enable_reg <=
                    avs_writedata_i[`DTSC_SETUP_REQ_BIT];
            end else if (secure_reg) begin
                trace_request_enable_reg <= 1'b0;
            end
            if (wr_setup && !arm_reg) begin
                trace_mode_select_reg <= dtsc_trace_mode_type'(
                    avs_writedata_i[`DTSC_SETUP_MODE_LSB +: 2]);
                trigger_alignment_reg <=
                    avs_writedata_i[`DTSC_SETUP_ALIGN_BIT];
            end
        end
    end

    // pairing field
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_reset_i) begin
            comparator_pairing_field_reg <= DTSC_PAIR_SEPARATE;
        end else begin
            if (wr_pair && !arm_reg) begin
                comparator_pairing_field_reg <=
                    dtsc_pairing_type'(avs_writedata_i[1:0]);
            end
        end
    end

    assign inside_range = above_a_i && below_b_i;
    always_comb begin
        match0_next = 1'b0;
        match1_next = 1'b0;
        case (comparator_pairing_field_reg)
            DTSC_PAIR_SEPARATE: begin
                match0_next = cmp_a_hit_i;
                match1_next = cmp_b_hit_i;
            end
            DTSC_PAIR_INSIDE: match0_next = inside_range;
            DTSC_PAIR_OUTSIDE: match0_next = !inside_range;
            default: match0_next = cmp_a_hit_i;
        endcase
    end

    // registered outputs; read permission lags the bits by one cycle
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_reset_i) begin
            match0_reg <= 1'b0;
            match1_reg <= 1'b0;
            read_allow_reg <= 1'b0;
        end else begin
            match0_reg <= match0_next;
            match1_reg <= match1_next;
            read_allow_reg <= trace_request_enable_reg && !arm_reg;
        end
    end
    assign status_rd = {buffer_full_flag_reg, 4'h0,
        sequencer_state_field_reg};
    assign count_rd = {buffer_full_flag_reg, 1'b0, line_count_reg};
    // trigger bit always reads zero
    assign ctrl_rd = {arm_reg, 5'h00, visibility_reg};
    assign setup_rd = {1'b0, trace_request_enable_reg, 2'b00,
        trace_mode_select_reg, 1'b0, trigger_alignment_reg};
    assign pair_rd = {6'h00, comparator_pairing_field_reg};

    always_comb begin
        rd_byte = `DTSC_BYTE_ZERO;
        if (addr_ok) begin
            case (reg_idx)
                `DTSC_IDX_CONTROL: rd_byte = ctrl_rd;
                `DTSC_IDX_STATUS: rd_byte = status_rd;
                `DTSC_IDX_SETUP: rd_byte = setup_rd;
                `DTSC_IDX_PAIRING: rd_byte = pair_rd;
                `DTSC_IDX_COUNT: rd_byte = count_rd;
                default: rd_byte = `DTSC_BYTE_ZERO;
            endcase
        end
    end
    // read data captured in the wait cycle so it stands at the answer edge
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_reset_i) begin
            readdata_reg <= `DTSC_WORD_ZERO;
        end else if (avs_read_i && bus_state_reg == DTSC_BUS_WAIT) begin
            readdata_reg <= {24'h00_0000, rd_byte};
        end
    end
    assign avs_readdata_o = readdata_reg;
    // the one-hot wait bit is the flip-flop itself
    assign avs_waitrequest_o = bus_state_reg[0];
    assign armed_o = arm_reg;
    assign immediate_trigger_o = trigger_reg;
    assign comparator_visibility_o = visibility_reg;
    assign trace_enable_o = trace_request_enable_reg;
    assign trace_read_allow_o = read_allow_reg;
    assign trace_mode_o = trace_mode_select_reg;
    assign trigger_alignment_o = trigger_alignment_reg;
    assign match0_o = match0_reg;
    assign match1_o = match1_reg;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i || por_reset_i);
    property p_full_on_wrap;
        count_wrap |=> buffer_full_flag_reg && line_count_reg == 6'h00;
    endproperty
    a_full_on_wrap: assert property (p_full_on_wrap)
        else $error("full flag not set on line wrap");
    property p_arm_clears_full;
        arm_set && !count_wrap |=> !buffer_full_flag_reg;
    endproperty
    a_arm_clears_full: assert property (p_arm_clears_full)
        else $error("arming did not clear full flag");
    property p_full_survives_reset;
        @(posedge core_clk_i) disable iff (por_reset_i)
        reset_i |=> buffer_full_flag_reg == $past(buffer_full_flag_reg);
    endproperty
    a_full_survives_reset: assert property (p_full_survives_reset)
        else $error("system reset changed full flag");
    property p_mirror;
        avs_read_i && avs_waitrequest_o && addr_ok
            && (reg_idx == `DTSC_IDX_STATUS || reg_idx == `DTSC_IDX_COUNT)
        |=> avs_readdata_o[7] == $past(buffer_full_flag_reg);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("full flag read back wrong");
    property p_follow_state;
        arm_reg && seq_state_valid_i && seq_state_i <= 3'h4 && !wr_ctrl
            && !session_end_i
        |=> sequencer_state_field_reg == $past(seq_state_i);
    endproperty
    a_follow_state: assert property (p_follow_state)
        else $error("state field missed a transition");
    property p_disarm_holds;
        arm_clear_sw && !session_end_i |=> $stable(sequencer_state_field_reg);
    endproperty
    a_disarm_holds: assert property (p_disarm_holds)
        else $error("state field changed after software disarm");
    property p_end_clears;
        session_end_i && arm_reg && !wr_ctrl
        |=> !arm_reg && sequencer_state_field_reg == 3'h0;
    endproperty
    a_end_clears: assert property (p_end_clears)
        else $error("internal end did not clear state");
    property p_arm_state_one;
        arm_set |=> arm_reg && sequencer_state_field_reg == 3'h1;
    endproperty
    a_arm_state_one: assert property (p_arm_state_one)
        else $error("arming did not force state one");
    property p_no_reserved;
        sequencer_state_field_reg <= 3'h4;
    endproperty
    a_no_reserved: assert property (p_no_reserved)
        else $error("reserved state code shown");
    property p_secure_blocks;
        secure_reg |=> !trace_enable_o;
    endproperty
    a_secure_blocks: assert property (p_secure_blocks)
        else $error("tracing enabled while secure");
    property p_req_locked;
        wr_setup && (arm_reg || secure_reg) |=> !$rose(trace_enable_o);
    endproperty
    a_req_locked: assert property (p_req_locked)
        else $error("trace enable written while locked");
    property p_mode_locked;
        arm_reg |=> $stable(trace_mode_o) && $stable(trigger_alignment_o);
    endproperty
    a_mode_locked: assert property (p_mode_locked)
        else $error("mode or alignment changed while armed");
    property p_pair_locked;
        arm_reg |=> $stable(comparator_pairing_field_reg);
    endproperty
    a_pair_locked: assert property (p_pair_locked)
        else $error("pairing changed while armed");
    property p_single_match;
        comparator_pairing_field_reg != DTSC_PAIR_SEPARATE
            && $stable(comparator_pairing_field_reg) |=> !match1_o;
    endproperty
    a_single_match: assert property (p_single_match)
        else $error("match 1 active in paired mode");
    property p_inside;
        comparator_pairing_field_reg == DTSC_PAIR_INSIDE
        |=> match0_o == $past(inside_range);
    endproperty
    a_inside: assert property (p_inside)
        else $error("inside range match wrong");
    property p_outside;
        comparator_pairing_field_reg == DTSC_PAIR_OUTSIDE
        |=> match0_o == !$past(inside_range);
    endproperty
    a_outside: assert property (p_outside)
        else $error("outside range match wrong");

    c_wrap: cover property (count_wrap);
    c_end_session: cover property (arm_reg ##1 session_end_i);
    c_arm_then_disarm: cover property (arm_set ##[1:20] arm_clear_sw);
    c_inside_hit: cover property (
        comparator_pairing_field_reg == DTSC_PAIR_INSIDE && match0_o);

endmodule // dtsc_top
